/* File: src/tcoc_top.v */
`timescale 1ns/100ps
`include "tcoc_defs.vh"

module tcoc_top #(
  parameter W = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire timer_tick,
  output wire wave_out_a,
  output wire wave_out_b,
  output wire pin_override_a,
  output wire pin_override_b,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg [7:0] timer_control_a_q;
  reg [7:0] timer_control_b_q;
  reg [W-1:0] cmp_buf_a_q;
  reg [W-1:0] cmp_buf_b_q;
  reg [W-1:0] cmp_act_a_q;
  reg [W-1:0] cmp_act_b_q;
  reg [W-1:0] capture_value_q;
  reg [`TCOC_IRQ_W-1:0] irq_stat_q;
  reg [`TCOC_IRQ_W-1:0] irq_en_q;
  reg wr_pend_q;
  reg [`TCOC_ADDR_W-1:0] wr_addr_q;
  reg [31:0] rd_d;
  reg [W-1:0] top_d;
  reg upd_at_top;
  reg upd_at_bot;
  reg ovf_evt;
  wire [3:0] waveform_select;
  wire [1:0] cls;
  wire [1:0] cmp_out_mode_a;
  wire [1:0] cmp_out_mode_b;
  wire [W-1:0] count_value;
  wire count_down;
  wire at_top;
  wire at_bottom;
  wire match_a;
  wire match_b;
  wire addr_ok;
  wire [`TCOC_ADDR_W-1:0] addr_lo;
  wire [`TCOC_IRQ_W-1:0] irq_evt;
  wire [`TCOC_IRQ_W-1:0] irq_clr;
  wire upd_now;

  ////////////////////////////////////////////////////////////////////////////
  // Mode class decode from the four-bit waveform mode
  function [1:0] mode_class;
    input [3:0] wm;
    begin
      case (wm)
        4'h0, 4'hd: mode_class = `TCOC_CLS_NORM;
        4'h4, 4'hc: mode_class = `TCOC_CLS_CTC;
        4'h5, 4'h6, 4'h7, 4'he, 4'hf: mode_class = `TCOC_CLS_FAST;
        default: mode_class = `TCOC_CLS_DUAL;
      endcase
    end
  endfunction

  // Waveform mode joined from both control registers
  assign waveform_select = {timer_control_b_q[`TCOC_CB_WAVE_HI:`TCOC_CB_WAVE_LO],
    timer_control_a_q[`TCOC_CA_WAVE_HI:`TCOC_CA_WAVE_LO]};
  assign cls = mode_class(waveform_select);
  // Field placement inside control register A
  assign cmp_out_mode_a =
    timer_control_a_q[`TCOC_CA_MODE_A_HI:`TCOC_CA_MODE_A_LO];
  assign cmp_out_mode_b =
    timer_control_a_q[`TCOC_CA_MODE_B_HI:`TCOC_CA_MODE_B_LO];

  ////////////////////////////////////////////////////////////////////////////
  // TOP source and buffer update point per mode
  always @* begin
    top_d = `TCOC_MAX;
    upd_at_top = 1'b0;
    upd_at_bot = 1'b0;
    case (waveform_select)
      4'h1: begin
        top_d = `TCOC_TOP_8;
        upd_at_top = 1'b1;
      end
      4'h2: begin
        top_d = `TCOC_TOP_9;
        upd_at_top = 1'b1;
      end
      4'h3: begin
        top_d = `TCOC_TOP_10;
        upd_at_top = 1'b1;
      end
      4'h4: top_d = cmp_act_a_q;
      4'h5: begin
        top_d = `TCOC_TOP_8;
        upd_at_bot = 1'b1;
      end
      4'h6: begin
        top_d = `TCOC_TOP_9;
        upd_at_bot = 1'b1;
      end
      4'h7: begin
        top_d = `TCOC_TOP_10;
        upd_at_bot = 1'b1;
      end
      `TCOC_WM_PFC_ICR, `TCOC_WM_FAST_ICR: begin
        top_d = capture_value_q;
        upd_at_bot = 1'b1;
      end
      `TCOC_WM_PFC_CMP, `TCOC_WM_FAST_CMP: begin
        top_d = cmp_act_a_q;
        upd_at_bot = 1'b1;
      end
      `TCOC_WM_PC_ICR: begin
        top_d = capture_value_q;
        upd_at_top = 1'b1;
      end
      `TCOC_WM_PC_CMP: begin
        top_d = cmp_act_a_q;
        upd_at_top = 1'b1;
      end
      4'hc: top_d = capture_value_q;
      default: top_d = `TCOC_MAX;
    endcase
  end

  // Overflow flag point follows the class
  always @* begin
    case (cls)
      `TCOC_CLS_FAST: ovf_evt = timer_tick && at_top;
      `TCOC_CLS_DUAL: ovf_evt = timer_tick && at_bottom;
      default: ovf_evt = timer_tick && (count_value == `TCOC_MAX);
    endcase
  end

  // Buffered loads only on qualifying ticks, immediate otherwise
  assign upd_now = (!upd_at_top && !upd_at_bot) ||
    (timer_tick && ((upd_at_top && at_top) || (upd_at_bot && at_bottom)));

  // Active compare values
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_act_a_q <= `TCOC_RST_WORD;
      cmp_act_b_q <= `TCOC_RST_WORD;
    end else if (upd_now) begin
      cmp_act_a_q <= cmp_buf_a_q;
      cmp_act_b_q <= cmp_buf_b_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and the two output channels
  tcoc_counter #(
    .W(W)
  ) u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(timer_tick),
    .cls(cls),
    .top(top_d),
    .count_q(count_value),
    .down_q(count_down),
    .at_top(at_top),
    .at_bottom(at_bottom)
  );

  tcoc_chan #(
    .W(W),
    .IS_A(1)
  ) u_chan_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(timer_tick),
    .com(cmp_out_mode_a),
    .wave_mode(waveform_select),
    .cls(cls),
    .count(count_value),
    .cmp(cmp_act_a_q),
    .top(top_d),
    .down(count_down),
    .at_bottom(at_bottom),
    .wave_q(wave_out_a),
    .match(match_a),
    .override(pin_override_a)
  );

  tcoc_chan #(
    .W(W),
    .IS_A(0)
  ) u_chan_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(timer_tick),
    .com(cmp_out_mode_b),
    .wave_mode(waveform_select),
    .cls(cls),
    .count(count_value),
    .cmp(cmp_act_b_q),
    .top(top_d),
    .down(count_down),
    .at_bottom(at_bottom),
    .wave_q(wave_out_b),
    .match(match_b),
    .override(pin_override_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_lo = haddr[`TCOC_ADDR_W-1:0];
  assign addr_ok = hsel && hready && htrans[1];

  // Address phase capture for writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {`TCOC_ADDR_W{1'b0}};
    end else if (hready) begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= addr_lo;
    end
  end

  // Read mux, unmapped addresses read zero
  always @* begin
    rd_d = 32'h0000_0000;
    case (addr_lo)
      `TCOC_OFS_CTRL_A: rd_d[7:0] = timer_control_a_q;
      `TCOC_OFS_CTRL_B: rd_d[7:0] = timer_control_b_q;
      `TCOC_OFS_CMP_A: rd_d[W-1:0] = cmp_buf_a_q;
      `TCOC_OFS_CMP_B: rd_d[W-1:0] = cmp_buf_b_q;
      `TCOC_OFS_CAPTURE: rd_d[W-1:0] = capture_value_q;
      `TCOC_OFS_COUNT: rd_d[W-1:0] = count_value;
      `TCOC_OFS_IRQ_STAT: rd_d[`TCOC_IRQ_W-1:0] = irq_stat_q;
      `TCOC_OFS_IRQ_EN: rd_d[`TCOC_IRQ_W-1:0] = irq_en_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data registered for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_control_a_q <= `TCOC_RST_CTRL;
      timer_control_b_q <= `TCOC_RST_CTRL;
      cmp_buf_a_q <= `TCOC_RST_WORD;
      cmp_buf_b_q <= `TCOC_RST_WORD;
      capture_value_q <= `TCOC_RST_WORD;
      irq_en_q <= {`TCOC_IRQ_W{1'b0}};
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `TCOC_OFS_CTRL_A: timer_control_a_q <= hwdata[7:0] & `TCOC_CA_MASK;
        `TCOC_OFS_CTRL_B: timer_control_b_q <= hwdata[7:0] & `TCOC_CB_MASK;
        `TCOC_OFS_CMP_A: cmp_buf_a_q <= hwdata[W-1:0];
        `TCOC_OFS_CMP_B: cmp_buf_b_q <= hwdata[W-1:0];
        `TCOC_OFS_CAPTURE: capture_value_q <= hwdata[W-1:0];
        `TCOC_OFS_IRQ_EN: irq_en_q <= hwdata[`TCOC_IRQ_W-1:0];
        default: irq_en_q <= irq_en_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, write-one clear, set wins over clear
  assign irq_evt = {ovf_evt, match_b, match_a};
  assign irq_clr = (wr_pend_q && wr_addr_q == `TCOC_OFS_IRQ_CLR) ?
    hwdata[`TCOC_IRQ_W-1:0] : {`TCOC_IRQ_W{1'b0}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= {`TCOC_IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
    end
  end

  // Level interrupt while any enabled bit is set
  assign irq = |(irq_stat_q & irq_en_q);

endmodule

/* File: src/tcoc_defs.vh */
// Overview of operation
// - Timer runs on the bus clock; the timer tick enables counting, compare matches, BOTTOM actions, overflow flags and buffered loads.
// - Phase and frequency correct PWM loads compare values from buffer at BOTTOM.
// - Any nonzero compare output mode bit hands the pin to the waveform output.
// - Compare output mode meaning depends on normal/CLEAR_ON_MATCH_MODE, fast PWM or dual-slope.
// - Normal/CLEAR_ON_MATCH_MODE match: 00 disconnected, 01 toggle, 10 drive low, 11 drive high.
// - Fast PWM mode field 01 toggles output A only in modes 14 and 15.
// - Fast PWM 10: clear on compare match, set at BOTTOM.
// - Fast PWM 11: set on compare match, clear at BOTTOM.
// - Fast PWM: match ignored when compare equals TOP, BOTTOM action still done.
// - Dual-slope mode field 01 toggles output A only in modes 9 and 11.
// - Dual-slope 10: clear on match counting up, set on match counting down.
// - Dual-slope 11: set on match counting up, clear on match counting down.
// - Control register A at 0x80, reset 0x00; modes 7:4, waveform bits 1:0.
// - Waveform mode joins two bits of register A with two of register B.
// - Dual-slope counter runs zero up to TOP and back, giving direction.
`ifndef TCOC_DEFS_VH
`define TCOC_DEFS_VH

// Register byte addresses
`define TCOC_ADDR_W 12
`define TCOC_OFS_CTRL_A 12'h080
`define TCOC_OFS_CTRL_B 12'h084
`define TCOC_OFS_CMP_A 12'h088
`define TCOC_OFS_CMP_B 12'h08c
`define TCOC_OFS_CAPTURE 12'h090
`define TCOC_OFS_COUNT 12'h094
`define TCOC_OFS_IRQ_STAT 12'h098
`define TCOC_OFS_IRQ_CLR 12'h09c
`define TCOC_OFS_IRQ_EN 12'h0a0

// Field positions
`define TCOC_CA_MODE_A_HI 7
`define TCOC_CA_MODE_A_LO 6
`define TCOC_CA_MODE_B_HI 5
`define TCOC_CA_MODE_B_LO 4
`define TCOC_CA_WAVE_HI 1
`define TCOC_CA_WAVE_LO 0
`define TCOC_CB_WAVE_HI 4
`define TCOC_CB_WAVE_LO 3
`define TCOC_CA_MASK 8'hf3
`define TCOC_CB_MASK 8'h18

// Reset values
`define TCOC_RST_CTRL 8'h00
`define TCOC_RST_WORD 16'h0000

// Interrupt status bits
`define TCOC_IRQ_W 3
`define TCOC_IRQ_MATCH_A 0
`define TCOC_IRQ_MATCH_B 1
`define TCOC_IRQ_OVF 2

// Counter limits
`define TCOC_BOTTOM 16'h0000
`define TCOC_MAX 16'hffff
`define TCOC_TOP_8 16'h00ff
`define TCOC_TOP_9 16'h01ff
`define TCOC_TOP_10 16'h03ff

// Mode classes
`define TCOC_CLS_NORM 2'h0
`define TCOC_CLS_CTC 2'h1
`define TCOC_CLS_FAST 2'h2
`define TCOC_CLS_DUAL 2'h3

// Waveform modes named for special cases
`define TCOC_WM_FAST_ICR 4'he
`define TCOC_WM_FAST_CMP 4'hf
`define TCOC_WM_PFC_ICR 4'h8
`define TCOC_WM_PFC_CMP 4'h9
`define TCOC_WM_PC_ICR 4'ha
`define TCOC_WM_PC_CMP 4'hb

// Compare output mode field values
`define TCOC_COM_OFF 2'h0
`define TCOC_COM_TOGGLE 2'h1
`define TCOC_COM_CLEAR 2'h2
`define TCOC_COM_SET 2'h3

`endif

/* File: src/tcoc_counter.v */
`timescale 1ns/100ps
`include "tcoc_defs.vh"

module tcoc_counter #(
  parameter W = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire tick,
  input wire [1:0] cls,
  input wire [W-1:0] top,
  output reg [W-1:0] count_q,
  output reg down_q,
  output wire at_top,
  output wire at_bottom
);

  assign at_top = (count_q == top);
  assign at_bottom = (count_q == `TCOC_BOTTOM);

  // Counting sequence, advanced only on ticks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `TCOC_RST_WORD;
      down_q <= 1'b0;
    end else if (tick) begin
      case (cls)
        `TCOC_CLS_NORM: begin
          count_q <= count_q + 1'b1;
          down_q <= 1'b0;
        end
        `TCOC_CLS_CTC, `TCOC_CLS_FAST: begin
          count_q <= at_top ? `TCOC_BOTTOM : count_q + 1'b1;
          down_q <= 1'b0;
        end
        `TCOC_CLS_DUAL: begin
          // Up to TOP, down to BOTTOM, each held one tick
          if (!down_q) begin
            if (count_q >= top) begin
              down_q <= 1'b1;
              count_q <= at_bottom ? `TCOC_BOTTOM : count_q - 1'b1;
            end else begin
              count_q <= count_q + 1'b1;
            end
          end else if (at_bottom) begin
            down_q <= 1'b0;
            count_q <= at_top ? `TCOC_BOTTOM : count_q + 1'b1;
          end else begin
            count_q <= count_q - 1'b1;
          end
        end
        default: begin
          count_q <= count_q;
          down_q <= down_q;
        end
      endcase
    end
  end

endmodule

/* File: src/tcoc_chan.v */
`timescale 1ns/100ps
`include "tcoc_defs.vh"

module tcoc_chan #(
  parameter W = 16,
  parameter IS_A = 1
) (
  input wire hclk,
  input wire hresetn,
  input wire tick,
  input wire [1:0] com,
  input wire [3:0] wave_mode,
  input wire [1:0] cls,
  input wire [W-1:0] count,
  input wire [W-1:0] cmp,
  input wire [W-1:0] top,
  input wire down,
  input wire at_bottom,
  output reg wave_q,
  output wire match,
  output wire override
);

  wire toggle_ok;

  // Match on the tick in which count equals compare
  assign match = tick && (count == cmp);
  // Pin handed over whenever the field is nonzero
  assign override = |com;
  // Toggle allowed only for channel A in fast modes 14 and 15 and dual-slope modes 9 and 11
  assign toggle_ok = (IS_A != 0) && ((cls == `TCOC_CLS_FAST) ?
    (wave_mode == `TCOC_WM_FAST_ICR || wave_mode == `TCOC_WM_FAST_CMP) :
    (wave_mode == `TCOC_WM_PFC_CMP || wave_mode == `TCOC_WM_PC_CMP));

  // Waveform register, action decided by mode class
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_q <= 1'b0;
    end else begin
      case (cls)
        `TCOC_CLS_NORM, `TCOC_CLS_CTC: begin
          if (match) begin
            case (com)
              `TCOC_COM_TOGGLE: wave_q <= ~wave_q;
              `TCOC_COM_CLEAR: wave_q <= 1'b0;
              `TCOC_COM_SET: wave_q <= 1'b1;
              default: wave_q <= wave_q;
            endcase
          end
        end
        `TCOC_CLS_FAST: begin
          if (com == `TCOC_COM_TOGGLE) begin
            if (match && toggle_ok) wave_q <= ~wave_q;
          end else if (com[1]) begin
            // Compare equal to TOP skips match, BOTTOM still acts
            if (match && cmp != top) begin
              wave_q <= com[0];
            end else if (tick && at_bottom) begin
              wave_q <= ~com[0];
            end
          end
        end
        `TCOC_CLS_DUAL: begin
          if (com == `TCOC_COM_TOGGLE) begin
            if (match && toggle_ok) wave_q <= ~wave_q;
          end else if (com[1] && match) begin
            wave_q <= com[0] ^ down;
          end
        end
        default: wave_q <= wave_q;
      endcase
    end
  end

endmodule

/* File: test/tcoc_pin_model.sv */
`timescale 1ns/100ps
module tcoc_pin_model (
  input wire wave,
  input wire override,
  input wire dir,
  input wire port_out,
  output wire pad
);
  // Pull-up holds a released pad high; waveform takes the pin from port data
  assign pad = !dir ? 1'b1 : (override ? wave : port_out);
endmodule

/* File: test/tcoc_props.sv */
`timescale 1ns/100ps
`include "tcoc_defs.vh"
module tcoc_props #(
  parameter W = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire timer_tick,
  input wire wave_out_a,
  input wire wave_out_b,
  input wire pin_override_a,
  input wire pin_override_b,
  input wire irq
);
  reg wr_q;
  reg [11:0] wa_q;
  reg [7:0] ca_q;
  reg [7:0] cb_q;
  wire [3:0] wm = {cb_q[4:3], ca_q[1:0]};
  wire nonpwm = (wm == 4'h0) || (wm == 4'h4) || (wm[3:1] == 3'h6);
  wire fast = (wm[3:2] == 2'h1 && wm[1:0] != 2'h0) || (wm[3:1] == 3'h7);
  wire dual = !nonpwm && !fast;
  wire clr_a = nonpwm && ca_q[7:6] == 2'h2;
  wire set_b = nonpwm && ca_q[5:4] == 2'h3;
  wire tgl_b = fast && ca_q[5:4] == 2'h1;
  wire tgl_a = dual && ca_q[7:6] == 2'h1 && wm != 4'h9 && wm != 4'hb;
  ////////////////////////////////////////////////////////////
  // Shadow of the control registers, written as the data phase ends
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 12'h000;
      ca_q <= 8'h00;
      cb_q <= 8'h00;
    end else begin
      if (wr_q && wa_q == `TCOC_OFS_CTRL_A)
        ca_q <= hwdata[7:0] & `TCOC_CA_MASK;
      if (wr_q && wa_q == `TCOC_OFS_CTRL_B)
        cb_q <= hwdata[7:0] & `TCOC_CB_MASK;
      wr_q <= hsel && hready && htrans[1] && hwrite;
      wa_q <= haddr[11:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase of control register A
  sequence rd_ctrl_s;
    hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `TCOC_OFS_CTRL_A;
  endsequence
  override_a_a: assert property (pin_override_a == (ca_q[7:6] != 2'h0))
    else $error("override a wrong");
  override_b_a: assert property (pin_override_b == (ca_q[5:4] != 2'h0))
    else $error("override b wrong");
  ctrl_read_a: assert property (rd_ctrl_s |=> hrdata == {24'h0, $past(ca_q)})
    else $error("control a readback wrong");
  tick_only_a: assert property (!timer_tick |=> $stable(wave_out_a) && $stable(wave_out_b))
    else $error("wave moved without tick");
  clear_only_a: assert property (clr_a ##1 clr_a |-> !$rose(wave_out_a))
    else $error("clear mode raised a");
  set_only_a: assert property (set_b ##1 set_b |-> !$fell(wave_out_b))
    else $error("set mode lowered b");
  fast_b_off_a: assert property (tgl_b ##1 tgl_b |-> $stable(wave_out_b))
    else $error("fast b toggled");
  dual_a_off_a: assert property (tgl_a ##1 tgl_a |-> $stable(wave_out_a))
    else $error("dual a toggled");
endmodule

bind tcoc_top tcoc_props #(.W(W)) i_tcoc_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_tick(timer_tick),
  .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .pin_override_a(pin_override_a),
  .pin_override_b(pin_override_b), .irq(irq)
);

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`include "tcoc_defs.vh"
module tb_top;
  reg hclk;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg timer_tick = 1'b0;
  reg pin_dir = 1'b0;
  reg [31:0] rd;
  reg [3:0] wm;
  reg [31:0] wm_tab = 32'ha685bf9e;
  wire hreadyout, hresp, wave_out_a, wave_out_b, pin_override_a, pin_override_b, irq;
  wire pad_a, pad_b;
  wire [31:0] hrdata;
  integer bad_count = 0;
  integer checks_done = 0;
  integer i;
  tcoc_top #(.W(16)) i_tcoc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer_tick(timer_tick), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .pin_override_a(pin_override_a), .pin_override_b(pin_override_b), .irq(irq));
  tcoc_pin_model i_pad_a (.wave(wave_out_a), .override(pin_override_a), .dir(pin_dir),
    .port_out(1'b0), .pad(pad_a));
  tcoc_pin_model i_pad_b (.wave(wave_out_b), .override(pin_override_b), .dir(pin_dir),
    .port_out(1'b0), .pad(pad_b));
  // Clock generator
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task check_bit(input string name, input logic exp, input logic got);
    begin
      check_word(name, {31'h0, exp}, {31'h0, got});
    end
  endtask
  // One single AHB-Lite transfer; read data lands in rd
  task ahb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hsel <= 1'b0;
      #1;
    end
  endtask
  task ticks(input integer n);
    begin
      repeat (n) begin
        @(posedge hclk);
        timer_tick <= 1'b1;
      end
      @(posedge hclk);
      timer_tick <= 1'b0;
      #1;
    end
  endtask
  task do_reset;
    begin
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
    end
  endtask
  task setup(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] ma,
             input logic [15:0] mb, input logic [15:0] cap);
    begin
      do_reset;
      ahb_xfer(1'b1, `TCOC_OFS_CMP_A, {16'h0, ma});
      ahb_xfer(1'b1, `TCOC_OFS_CMP_B, {16'h0, mb});
      ahb_xfer(1'b1, `TCOC_OFS_CAPTURE, {16'h0, cap});
      ahb_xfer(1'b1, `TCOC_OFS_CTRL_B, {24'h0, cb});
      ahb_xfer(1'b1, `TCOC_OFS_CTRL_A, {24'h0, ca});
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count = bad_count + 1;
    give_verdict;
  end
  // Main sequence
  initial begin
    do_reset;
    ahb_xfer(1'b0, `TCOC_OFS_CTRL_A, 32'h0);
    check_word("ctrl_a reset", 32'h0, rd);
    ahb_xfer(1'b1, `TCOC_OFS_CTRL_A, 32'hff);
    ahb_xfer(1'b0, `TCOC_OFS_CTRL_A, 32'h0);
    check_word("ctrl_a bits", 32'hf3, rd);
    ahb_xfer(1'b1, `TCOC_OFS_CTRL_B, 32'hff);
    ahb_xfer(1'b0, `TCOC_OFS_CTRL_B, 32'h0);
    check_word("ctrl_b bits", 32'h18, rd);
    ahb_xfer(1'b1, `TCOC_OFS_CTRL_A, 32'h40);
    check_bit("override a", 1'b1, pin_override_a);
    check_bit("override b", 1'b0, pin_override_b);
    check_bit("pad released", 1'b1, pad_a);
    ahb_xfer(1'b0, 12'h0fc, 32'h0);
    check_word("unmapped", 32'h0, rd);
    check_bit("hresp okay", 1'b0, hresp);
    $display("test registers done");
    setup(8'h70, 8'h00, 16'h5, 16'h7, 16'h0);
    pin_dir = 1'b1;
    ahb_xfer(1'b1, `TCOC_OFS_IRQ_EN, 32'h1);
    ticks(5);
    check_bit("wave a early", 1'b0, wave_out_a);
    check_bit("irq early", 1'b0, irq);
    ticks(1);
    check_bit("wave a toggle", 1'b1, wave_out_a);
    check_bit("pad a", 1'b1, pad_a);
    check_bit("irq match", 1'b1, irq);
    ticks(2);
    check_bit("wave b set", 1'b1, wave_out_b);
    ahb_xfer(1'b0, `TCOC_OFS_IRQ_STAT, 32'h0);
    check_word("status", 32'h3, rd);
    ahb_xfer(1'b1, `TCOC_OFS_CMP_A, 32'h9);
    ahb_xfer(1'b1, `TCOC_OFS_CTRL_A, 32'hb0);
    ticks(2);
    check_bit("wave a clear", 1'b0, wave_out_a);
    ahb_xfer(1'b1, `TCOC_OFS_IRQ_EN, 32'h0);
    check_bit("irq masked", 1'b0, irq);
    ahb_xfer(1'b1, `TCOC_OFS_IRQ_EN, 32'h1);
    check_bit("irq unmasked", 1'b1, irq);
    ahb_xfer(1'b1, `TCOC_OFS_IRQ_CLR, 32'h3);
    check_bit("irq cleared", 1'b0, irq);
    ahb_xfer(1'b0, `TCOC_OFS_IRQ_STAT, 32'h0);
    check_word("status clear", 32'h0, rd);
    $display("test normal mode done");
    // Toggle setting across fast and dual-slope modes 14, 9, 15, 11, 5, 8, 6, 10
    for (i = 0; i < 8; i = i + 1) begin
      wm = wm_tab[4*i +: 4];
      setup({6'h14, wm[1:0]}, {3'h0, wm[3:2], 3'h0}, 16'h8, 16'h8, 16'h20);
      ticks(16);
      check_bit("toggle a", i < 4, wave_out_a);
      check_bit("toggle b", 1'b0, wave_out_b);
    end
    $display("test toggle modes done");
    setup(8'hb1, 8'h08, 16'h10, 16'h10, 16'h0);
    ticks(32);
    check_bit("fast a match", 1'b0, wave_out_a);
    check_bit("fast b match", 1'b1, wave_out_b);
    ticks(227);
    check_bit("fast a bottom", 1'b1, wave_out_a);
    check_bit("fast b bottom", 1'b0, wave_out_b);
    ahb_xfer(1'b0, `TCOC_OFS_IRQ_STAT, 32'h0);
    check_word("fast status", 32'h7, rd);
    setup(8'h81, 8'h08, 16'hff, 16'h10, 16'h0);
    ticks(256);
    check_bit("fast a at top", 1'b1, wave_out_a);
    ticks(3);
    check_bit("fast a wrap", 1'b1, wave_out_a);
    $display("test fast pwm done");
    setup(8'hb0, 8'h10, 16'h8, 16'h8, 16'h20);
    ticks(16);
    check_bit("dual a up", 1'b0, wave_out_a);
    check_bit("dual b up", 1'b1, wave_out_b);
    ahb_xfer(1'b1, `TCOC_OFS_CMP_A, 32'h18);
    ticks(28);
    check_bit("dual a buffered", 1'b0, wave_out_a);
    ahb_xfer(1'b0, `TCOC_OFS_COUNT, 32'h0);
    check_word("dual count", 32'h14, rd);
    ticks(20);
    check_bit("dual a down", 1'b1, wave_out_a);
    check_bit("dual b down", 1'b0, wave_out_b);
    $display("test dual slope done");
    give_verdict;
  end
endmodule
